// *** logic/tdm_serial_port_framing.sv ***
`timescale 1ns/1ps

module tdm_serial_port_framing
   import tdm_framing_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic [NUM_GROUPS-1:0] i_tx_line_clock,
   input wire logic [NUM_GROUPS-1:0] i_tx_frame_sync,
   input wire logic [NUM_GROUPS-1:0] i_rx_line_clock,
   input wire logic [NUM_GROUPS-1:0] i_rx_frame_sync,
   input wire logic [NUM_GROUPS-1:0] i_rx_serial_in,
   input wire logic [NUM_GROUPS-1:0] i_rx_out_of_frame_in,
   output logic [NUM_GROUPS-1:0] o_tx_serial_out,
   output logic [NUM_GROUPS-1:0] o_tx_serial_oe,
   output logic [NUM_GROUPS-1:0] o_out_of_frame_condition,
   output logic o_irq,
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready
);

   // Frame length of the selected mode
   function automatic logic [8:0] frame_len(input line_mode_t m);
      case (m)
         MODE_T1: frame_len = T1_FRAME_BITS;
         MODE_E1: frame_len = E1_FRAME_BITS;
         default: frame_len = NX64_FRAME_BITS;
      endcase
   endfunction
   // Counter step with wrap at the frame length
   function automatic logic [8:0] next_pos(input line_mode_t m, input logic [8:0] p);
      next_pos = (p == frame_len(m) - 9'h001) ? 9'h000 : p + 9'h001;
   endfunction
   // T1 puts the F-bit first, so slots start one bit later
   function automatic slot_pos_t slot_of(input line_mode_t m, input logic [8:0] p);
      logic [8:0] q;
      q = (m == MODE_T1) ? p - 9'h001 : p;
      slot_of.fbit = (m == MODE_T1) && (p == 9'h000);
      slot_of.slot = q[7:3];
      slot_of.bitn = q[2:0];
   endfunction
   function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
      for (int b = 0; b < 4; b++) begin
         apply_strb[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
      end
   endfunction
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a[1:0] == 2'h0) && ((a <= ADDR_LINE_STATE) || (a[7:5] == ADDR_RX_BYTE_PAGE));
   endfunction
   line_t pins;
   line_t meta_reg;
   line_t sync_reg;
   line_t prev_reg;
   cfg_t cfg_reg;
   logic [31:0] ts_map_reg;
   logic [7:0] tx_pattern_reg;
   logic [31:0] status_reg;
   logic [31:0] mask_reg;
   logic [8:0] tx_pos_reg [NUM_GROUPS];
   logic [8:0] rx_pos_reg [NUM_GROUPS];
   logic [7:0] rx_shift_reg [NUM_GROUPS];
   logic [7:0] rx_byte_reg [NUM_GROUPS];
   logic [NUM_GROUPS-1:0] tx_framed_reg, tx_arm_reg, tx_pend_reg, tx_frame_sync_prev_reg;
   logic [NUM_GROUPS-1:0] rx_framed_reg, rx_frame_sync_prev_reg, oof_reg;
   logic [NUM_GROUPS-1:0] tx_out_reg, tx_oe_reg;
   logic irq_reg;

   logic [8:0] tx_pos_next [NUM_GROUPS];
   logic [8:0] rx_pos_next [NUM_GROUPS];
   logic [7:0] rx_shift_next [NUM_GROUPS];
   logic [NUM_GROUPS-1:0] tx_framed_next, tx_arm_next, tx_pend_next, tx_out_next, tx_oe_next;
   logic [NUM_GROUPS-1:0] rx_framed_next, oof_next, byte_done;
   logic [31:0] status_set;

   // Edge events of the sampled line clocks
   wire [NUM_GROUPS-1:0] tx_line_clock_rise = sync_reg.tx_line_clock & ~prev_reg.tx_line_clock;
   wire [NUM_GROUPS-1:0] tx_line_clock_fall = ~sync_reg.tx_line_clock & prev_reg.tx_line_clock;
   wire [NUM_GROUPS-1:0] rclk_rise = sync_reg.rclk & ~prev_reg.rclk;
   wire [NUM_GROUPS-1:0] rclk_fall = ~sync_reg.rclk & prev_reg.rclk;
   wire [NUM_GROUPS-1:0] tx_smp = cfg_reg.tx_sync_edge_select ? tx_line_clock_fall : tx_line_clock_rise;
   wire [NUM_GROUPS-1:0] rx_smp = cfg_reg.rx_sync_edge_select ? rclk_fall : rclk_rise;
   wire [NUM_GROUPS-1:0] oof_smp = cfg_reg.oof_edge_select ? rclk_fall : rclk_rise;
   wire [NUM_GROUPS-1:0] tx_frame_sync_evt = tx_smp & sync_reg.tx_frame_sync & ~tx_frame_sync_prev_reg;
   wire [NUM_GROUPS-1:0] rx_frame_sync_evt = rx_smp & sync_reg.rx_frame_sync & ~rx_frame_sync_prev_reg;
   wire [NUM_GROUPS-1:0] oof_rise = oof_smp & sync_reg.rx_out_of_frame_in & ~oof_reg;
   wire [8:0] last_pos = frame_len(cfg_reg.mode) - 9'h001;
   wire [8:0] tx_reload = (cfg_reg.mode == MODE_NX64) ? NX64_FRAME_BITS - NX64_TX_LEAD : 9'h000;

   assign pins = '{tx_line_clock: i_tx_line_clock, tx_frame_sync: i_tx_frame_sync, rclk: i_rx_line_clock,
                   rx_frame_sync: i_rx_frame_sync, rx_serial_in: i_rx_serial_in, rx_out_of_frame_in: i_rx_out_of_frame_in};

   // Two-stage synchronizer, then a delayed copy for edge finding
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meta_reg <= '0;
         sync_reg <= '0;
         prev_reg <= '0;
      end else if (i_ce) begin
         meta_reg <= pins;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // Per-group transmit and receive framing
   always_comb begin
      slot_pos_t sp;
      slot_pos_t rp;
      logic start;
      logic wrap;
      logic drive;
      sp = '0;
      rp = '0;
      start = 1'b0;
      wrap = 1'b0;
      drive = 1'b0;
      status_set = '0;
      for (int g = 0; g < NUM_GROUPS; g++) begin
         // Transmit: rising line clock launches a bit; sync seen on the falling edge waits
         start = tx_line_clock_rise[g] & ((tx_frame_sync_evt[g] & ~cfg_reg.tx_sync_edge_select) | tx_pend_reg[g]);
         wrap = tx_line_clock_rise[g] & ~start & (tx_pos_reg[g] == last_pos);
         tx_pend_next[g] = (tx_frame_sync_evt[g] & cfg_reg.tx_sync_edge_select) |
                           (tx_pend_reg[g] & ~tx_line_clock_rise[g]);
         tx_pos_next[g] = ~tx_line_clock_rise[g] ? tx_pos_reg[g] :
                          start ? tx_reload : next_pos(cfg_reg.mode, tx_pos_reg[g]);
         tx_framed_next[g] = start | (wrap ? (cfg_reg.flywheel_align_mode | tx_arm_reg[g]) :
                                      tx_framed_reg[g]);
         tx_arm_next[g] = start ? (cfg_reg.mode == MODE_NX64) : (~wrap & tx_arm_reg[g]);
         sp = slot_of(cfg_reg.mode, tx_pos_next[g]);
         drive = tx_framed_next[g] & (sp.fbit | ts_map_reg[sp.slot]);
         tx_out_next[g] = tx_line_clock_rise[g] ? (~drive | sp.fbit | tx_pattern_reg[3'h7 - sp.bitn]) :
                          tx_out_reg[g];
         tx_oe_next[g] = tx_line_clock_rise[g] ? (drive | ~cfg_reg.tx_idle_tristate) : tx_oe_reg[g];
         status_set[ST_TX_FRAME + g] = tx_line_clock_rise[g] & tx_framed_next[g] & (tx_pos_next[g] == 9'h000);
         // Receive: counter keeps running through out-of-frame
         wrap = rx_smp[g] & ~rx_frame_sync_evt[g] & (rx_pos_reg[g] == last_pos);
         rx_pos_next[g] = ~rx_smp[g] ? rx_pos_reg[g] :
                          rx_frame_sync_evt[g] ? 9'h000 : next_pos(cfg_reg.mode, rx_pos_reg[g]);
         rx_framed_next[g] = rx_frame_sync_evt[g] | (wrap ? cfg_reg.flywheel_align_mode :
                                             rx_framed_reg[g]);
         oof_next[g] = oof_smp[g] ? sync_reg.rx_out_of_frame_in[g] : oof_reg[g];
         rp = slot_of(cfg_reg.mode, rx_pos_next[g]);
         start = rx_smp[g] & rx_framed_next[g] & ~rp.fbit & ts_map_reg[rp.slot] &
                 ~(cfg_reg.oof_abort_enable & oof_reg[g]);
         rx_shift_next[g] = start ? {rx_shift_reg[g][6:0], sync_reg.rx_serial_in[g]} : rx_shift_reg[g];
         byte_done[g] = start & (rp.bitn == 3'h7);
         status_set[ST_RX_FRAME + g] = rx_smp[g] & rx_framed_next[g] & (rx_pos_next[g] == 9'h000);
         status_set[ST_OOF_RISE + g] = oof_rise[g];
         status_set[ST_RX_BYTE + g] = byte_done[g];
      end
   end

   // Line-side state
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         for (int g = 0; g < NUM_GROUPS; g++) begin
            tx_pos_reg[g] <= '0;
            rx_pos_reg[g] <= '0;
            rx_shift_reg[g] <= '0;
            rx_byte_reg[g] <= '0;
         end
         {tx_framed_reg, tx_arm_reg, tx_pend_reg, tx_frame_sync_prev_reg} <= '0;
         {rx_framed_reg, rx_frame_sync_prev_reg, oof_reg} <= '0;
         tx_out_reg <= '1;
         tx_oe_reg <= '0;
      end else if (i_ce) begin
         for (int g = 0; g < NUM_GROUPS; g++) begin
            tx_pos_reg[g] <= tx_pos_next[g];
            rx_pos_reg[g] <= rx_pos_next[g];
            rx_shift_reg[g] <= rx_shift_next[g];
            if (byte_done[g]) begin
               rx_byte_reg[g] <= rx_shift_next[g];
            end
            if (tx_smp[g]) begin
               tx_frame_sync_prev_reg[g] <= sync_reg.tx_frame_sync[g];
            end
            if (rx_smp[g]) begin
               rx_frame_sync_prev_reg[g] <= sync_reg.rx_frame_sync[g];
            end
         end
         tx_framed_reg <= tx_framed_next;
         tx_arm_reg <= tx_arm_next;
         tx_pend_reg <= tx_pend_next;
         rx_framed_reg <= rx_framed_next;
         oof_reg <= oof_next;
         tx_out_reg <= tx_out_next;
         tx_oe_reg <= tx_oe_next;
      end
   end

   // Register bus handshakes and decode
   bus_state_t wr_state_reg;
   bus_state_t rd_state_reg;
   logic awready_reg, wready_reg, arready_reg, aw_have_reg, w_have_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;
   wire aw_hs = i_awvalid & awready_reg;
   wire w_hs = i_wvalid & wready_reg;
   wire ar_hs = i_arvalid & arready_reg;
   wire b_hs = (wr_state_reg == BUS_RESP) & i_bready;
   wire r_hs = (rd_state_reg == BUS_RESP) & i_rready;
   wire do_write = aw_have_reg & w_have_reg & (wr_state_reg == BUS_IDLE);
   wire [31:0] wr_word = apply_strb(32'h0000_0000, wdata_reg, wstrb_reg);
   wire wr_ctrl = do_write & (awaddr_reg == ADDR_CTRL);
   wire wr_map = do_write & (awaddr_reg == ADDR_TS_MAP);
   wire wr_pat = do_write & (awaddr_reg == ADDR_TX_PATTERN);
   wire wr_mask = do_write & (awaddr_reg == ADDR_MASK);
   wire rd_status = ar_hs & (i_araddr == ADDR_STATUS);
   wire [31:0] line_state = {8'h00, rx_framed_reg, tx_framed_reg, oof_reg};
   wire [31:0] rd_word =
      (i_araddr == ADDR_CTRL) ? {24'h000000, cfg_reg} :
      (i_araddr == ADDR_TS_MAP) ? ts_map_reg :
      (i_araddr == ADDR_TX_PATTERN) ? {24'h000000, tx_pattern_reg} :
      (i_araddr == ADDR_STATUS) ? status_reg :
      (i_araddr == ADDR_MASK) ? mask_reg :
      (i_araddr == ADDR_LINE_STATE) ? line_state :
      addr_ok(i_araddr) ? {24'h000000, rx_byte_reg[i_araddr[4:2]]} : 32'h0000_0000;
   // Read clears the bits it returned; a set in the same cycle survives
   wire [31:0] status_next = (status_reg & ~(rd_status ? status_reg : 32'h0000_0000)) | status_set;

   // Write channel
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wr_state_reg <= BUS_IDLE;
         {awready_reg, wready_reg} <= 2'h3;
         {aw_have_reg, w_have_reg} <= 2'h0;
         awaddr_reg <= '0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
         bresp_reg <= RESP_OKAY;
      end else if (i_ce) begin
         if (aw_hs) begin
            awaddr_reg <= i_awaddr;
            aw_have_reg <= 1'b1;
            awready_reg <= 1'b0;
         end
         if (w_hs) begin
            wdata_reg <= i_wdata;
            wstrb_reg <= i_wstrb;
            w_have_reg <= 1'b1;
            wready_reg <= 1'b0;
         end
         case (wr_state_reg)
            BUS_IDLE: begin
               if (do_write) begin
                  wr_state_reg <= BUS_RESP;
                  bresp_reg <= addr_ok(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
                  {aw_have_reg, w_have_reg} <= 2'h0;
               end
            end
            BUS_RESP: begin
               if (b_hs) begin
                  wr_state_reg <= BUS_IDLE;
                  {awready_reg, wready_reg} <= 2'h3;
               end
            end
            default: wr_state_reg <= BUS_IDLE;
         endcase
      end
   end

   // Configuration registers
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cfg_reg <= cfg_t'(CTRL_RESET);
         ts_map_reg <= TS_MAP_RESET;
         tx_pattern_reg <= TX_PATTERN_RESET;
         mask_reg <= MASK_RESET;
      end else if (i_ce) begin
         if (wr_ctrl && wstrb_reg[0]) begin
            cfg_reg <= cfg_t'(wr_word[7:0]);
         end
         if (wr_map) begin
            ts_map_reg <= apply_strb(ts_map_reg, wdata_reg, wstrb_reg);
         end
         if (wr_pat && wstrb_reg[0]) begin
            tx_pattern_reg <= wr_word[7:0];
         end
         if (wr_mask) begin
            mask_reg <= apply_strb(mask_reg, wdata_reg, wstrb_reg);
         end
      end
   end

   // Read channel, status and interrupt
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rd_state_reg <= BUS_IDLE;
         arready_reg <= 1'b1;
         rdata_reg <= '0;
         rresp_reg <= RESP_OKAY;
         status_reg <= '0;
         irq_reg <= 1'b0;
      end else if (i_ce) begin
         status_reg <= status_next;
         irq_reg <= |(status_reg & mask_reg);
         case (rd_state_reg)
            BUS_IDLE: begin
               if (ar_hs) begin
                  rd_state_reg <= BUS_RESP;
                  arready_reg <= 1'b0;
                  rdata_reg <= rd_word;
                  rresp_reg <= addr_ok(i_araddr) ? RESP_OKAY : RESP_SLVERR;
               end
            end
            BUS_RESP: begin
               if (r_hs) begin
                  rd_state_reg <= BUS_IDLE;
                  arready_reg <= 1'b1;
               end
            end
            default: rd_state_reg <= BUS_IDLE;
         endcase
      end
   end

   assign o_tx_serial_out = tx_out_reg;
   assign o_tx_serial_oe = tx_oe_reg;
   assign o_out_of_frame_condition = oof_reg;
   assign o_irq = irq_reg;
   assign o_awready = awready_reg;
   assign o_wready = wready_reg;
   assign o_bresp = bresp_reg;
   assign o_bvalid = (wr_state_reg == BUS_RESP);
   assign o_arready = arready_reg;
   assign o_rdata = rdata_reg;
   assign o_rresp = rresp_reg;
   assign o_rvalid = (rd_state_reg == BUS_RESP);
endmodule

// *** logic/tdm_framing_pkg.sv ***
package tdm_framing_pkg;

   // Channel groups and register word addresses
   localparam int unsigned NUM_GROUPS = 8;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_TS_MAP = 8'h04;
   localparam logic [7:0] ADDR_TX_PATTERN = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_MASK = 8'h10;
   localparam logic [7:0] ADDR_LINE_STATE = 8'h14;
   localparam logic [2:0] ADDR_RX_BYTE_PAGE = 3'h1;

   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [31:0] TS_MAP_RESET = 32'h0000_0000;
   localparam logic [7:0] TX_PATTERN_RESET = 8'hFF;
   localparam logic [31:0] MASK_RESET = 32'h0000_0000;

   // Status field bases, each field one bit per group
   localparam int unsigned ST_RX_FRAME = 0;
   localparam int unsigned ST_OOF_RISE = 8;
   localparam int unsigned ST_TX_FRAME = 16;
   localparam int unsigned ST_RX_BYTE = 24;

   // Line-side bit counts
   localparam logic [8:0] T1_FRAME_BITS = 9'h0C1;
   localparam logic [8:0] E1_FRAME_BITS = 9'h100;
   localparam logic [8:0] NX64_FRAME_BITS = 9'h100;
   localparam logic [8:0] NX64_TX_LEAD = 9'h004;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      MODE_T1 = 2'b00,
      MODE_E1 = 2'b01,
      MODE_NX64 = 2'b10
   } line_mode_t;

   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_RESP = 1'b1
   } bus_state_t;

   // Control word, bit 0 upward: mode, flywheel, tristate, abort, edges
   typedef struct packed {
      logic oof_edge_select;
      logic rx_sync_edge_select;
      logic tx_sync_edge_select;
      logic oof_abort_enable;
      logic tx_idle_tristate;
      logic flywheel_align_mode;
      line_mode_t mode;
   } cfg_t;

   // Serial pins of all groups
   typedef struct packed {
      logic [NUM_GROUPS-1:0] tx_line_clock;
      logic [NUM_GROUPS-1:0] tx_frame_sync;
      logic [NUM_GROUPS-1:0] rclk;
      logic [NUM_GROUPS-1:0] rx_frame_sync;
      logic [NUM_GROUPS-1:0] rx_serial_in;
      logic [NUM_GROUPS-1:0] rx_out_of_frame_in;
   } line_t;

   // Position of a bit inside the frame
   typedef struct packed {
      logic fbit;
      logic [4:0] slot;
      logic [2:0] bitn;
   } slot_pos_t;

endpackage

// *** testbench/tdm_line_partner.sv ***
`timescale 1ns/1ps

// Far-end framer model, one bit clock shared by all groups and both directions
module tdm_line_partner
   import tdm_framing_pkg::*;
(
   input wire logic i_run,
   input wire logic i_sync_req,
   input wire logic i_oof,
   input wire logic [7:0] i_rx_byte,
   output line_t o_line
);
   logic clk_q = 1'b0;
   logic sync_q = 1'b0;
   logic oof_q = 1'b0;
   logic [2:0] idx_q = 3'h0;
   wire bit_now = i_rx_byte[3'h7 - idx_q];

   // Bit clock of 400 ns, held low while no traffic is wanted
   always begin
      #200;
      clk_q = i_run & ~clk_q;
   end

   // Sync, data and out-of-frame move on the falling edge, clear of sampling
   always @(negedge clk_q) begin
      sync_q <= i_sync_req;
      oof_q <= i_oof;
      idx_q <= i_sync_req ? 3'h0 : idx_q + 3'h1;
   end

   // Same line state on every group; data inverts when the link stands still
   assign o_line.tx_line_clock = {NUM_GROUPS{clk_q}};
   assign o_line.rclk = {NUM_GROUPS{clk_q}};
   assign o_line.tx_frame_sync = {NUM_GROUPS{sync_q}};
   assign o_line.rx_frame_sync = {NUM_GROUPS{sync_q}};
   assign o_line.rx_out_of_frame_in = {NUM_GROUPS{oof_q}};
   assign o_line.rx_serial_in = {NUM_GROUPS{bit_now ^ ~i_run}};
endmodule

// *** testbench/tdm_serial_port_framing_properties.sv ***
`timescale 1ns/1ps

module tdm_framing_checker
   import tdm_framing_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic [NUM_GROUPS-1:0] i_tx_line_clock,
   input wire logic [NUM_GROUPS-1:0] i_rx_out_of_frame_in,
   input wire logic [NUM_GROUPS-1:0] o_tx_serial_out,
   input wire logic [NUM_GROUPS-1:0] o_out_of_frame_condition,
   input wire logic o_irq,
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic [1:0] o_bresp,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic [31:0] o_rdata,
   input wire logic [1:0] o_rresp,
   input wire logic o_rvalid
);
   logic tx_line_clock_q;
   logic mask_set_q;
   logic [3:0] since_q;
   wire [3:0] since_inc = (since_q == 4'hF) ? 4'hF : since_q + 4'h1;
   wire aw_hs = i_awvalid && o_awready;
   wire ar_bad = (i_araddr[1:0] != 2'h0) || (i_araddr > 8'h3C) ||
      (i_araddr > ADDR_LINE_STATE && i_araddr < 8'h20);

   // Age of the last group 0 transmit clock rise, and whether a mask was ever written
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tx_line_clock_q <= 1'b0;
         since_q <= 4'hF;
         mask_set_q <= 1'b0;
      end else begin
         tx_line_clock_q <= i_tx_line_clock[0];
         since_q <= (i_tx_line_clock[0] && !tx_line_clock_q) ? 4'h0 : since_inc;
         mask_set_q <= mask_set_q || (aw_hs && i_awaddr == ADDR_MASK);
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);

   chk_tx_launch: assert property ($changed(o_tx_serial_out[0]) |->
      since_q inside {[4'h1:4'h6]}) else $error("tx data moved off a clock launch");
   chk_oof_rise: assert property ($rose(o_out_of_frame_condition[0]) |->
      $past(i_rx_out_of_frame_in[0], 3)) else $error("oof rose without input");
   chk_oof_fall: assert property ($fell(o_out_of_frame_condition[0]) |->
      !$past(i_rx_out_of_frame_in[0], 3)) else $error("oof fell while input high");
   chk_irq_masked: assert property (!mask_set_q |-> !o_irq)
      else $error("irq with reset mask");
   chk_write_resp: assert property (aw_hs && i_wvalid && o_wready |-> ##[1:2] o_bvalid)
      else $error("write response late");
   chk_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped");
   chk_ready_back: assert property (o_bvalid && i_bready |=> o_awready && o_wready)
      else $error("write channels not ready again");
   chk_read_drop: assert property (i_arvalid && o_arready |=> !o_arready && o_rvalid)
      else $error("read answer missing");
   chk_read_err: assert property (i_arvalid && o_arready && ar_bad |=>
      o_rresp == RESP_SLVERR && o_rdata == 32'h0) else $error("bad read not refused");

   cover property ($rose(o_irq));
   cover property ($rose(o_out_of_frame_condition[0]));
   cover property (o_bvalid && o_bresp == RESP_SLVERR);
endmodule

bind tdm_serial_port_framing tdm_framing_checker u_chk (.i_mclk, .i_rst_b, .i_tx_line_clock,
   .i_rx_out_of_frame_in, .o_tx_serial_out, .o_out_of_frame_condition, .o_irq, .i_awaddr,
   .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
   .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid);

// *** testbench/tdm_serial_port_framing_tb_top.sv ***
`timescale 1ns/1ps

`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
   $display("mismatch at %0t: %h not %h", $time, (a), (b)); end end

module tdm_serial_port_framing_tb_top
   import tdm_framing_pkg::*;
;
   logic i_mclk = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_ce = 1'b1;
   logic [3:0] i_wstrb = 4'hF;
   logic [7:0] i_awaddr = 8'h00;
   logic [7:0] i_araddr = 8'h00;
   logic [31:0] i_wdata = 32'h0;
   logic i_awvalid = 1'b0;
   logic i_wvalid = 1'b0;
   logic i_bready = 1'b0;
   logic i_arvalid = 1'b0;
   logic i_rready = 1'b0;
   logic [7:0] o_tx_serial_out, o_tx_serial_oe, o_out_of_frame_condition;
   logic o_irq, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic [1:0] o_bresp, o_rresp;
   logic [31:0] o_rdata;
   line_t line;
   logic run = 1'b0;
   logic sync_req = 1'b0;
   logic out_of_frame_condition = 1'b0;
   logic [7:0] rx_byte = 8'h00;
   logic [0:263] bits;
   int err_total = 0;
   int check_count = 0;
   int cycles = 0;

   // System clock and timeout
   always #25 i_mclk = ~i_mclk;
   always @(posedge i_mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         test_done();
      end
   end

   tdm_line_partner far_end (.i_run(run), .i_sync_req(sync_req), .i_oof(out_of_frame_condition),
      .i_rx_byte(rx_byte), .o_line(line));
   tdm_serial_port_framing dut (.i_mclk, .i_rst_b, .i_ce, .i_tx_line_clock(line.tx_line_clock),
      .i_tx_frame_sync(line.tx_frame_sync), .i_rx_line_clock(line.rclk), .i_rx_frame_sync(line.rx_frame_sync),
      .i_rx_serial_in(line.rx_serial_in), .i_rx_out_of_frame_in(line.rx_out_of_frame_in), .o_tx_serial_out,
      .o_tx_serial_oe, .o_out_of_frame_condition, .o_irq, .i_awaddr, .i_awvalid, .o_awready,
      .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
      .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready);

   // Register write; bready waits for the response, which must stand meanwhile
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge i_mclk);
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      do begin
         @(posedge i_mclk);
         if (i_awvalid && o_awready) i_awvalid <= 1'b0;
         if (i_wvalid && o_wready) i_wvalid <= 1'b0;
         if (o_bvalid && !i_bready) i_bready <= 1'b1;
      end while (!(o_bvalid && i_bready));
      i_bready <= 1'b0;
      `CHK(o_bresp, er)
   endtask

   // Register read, response code checked, data returned
   task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
      @(posedge i_mclk);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      do begin
         @(posedge i_mclk);
         if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      end while (!o_rvalid);
      i_rready <= 1'b0;
      d = o_rdata;
      `CHK(o_rresp, er)
   endtask

   // One sync pulse of one bit period; the next clock rise is transmit frame position 0, or 252 in Nx64
   task automatic sync();
      @(posedge line.tx_line_clock[0]);
      sync_req <= 1'b1;
      @(negedge line.tx_line_clock[0]);
      sync_req <= 1'b0;
   endtask

   // Settled group 0 transmit bit after each launch
   task automatic grab(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge line.tx_line_clock[0]);
         repeat (6) @(posedge i_mclk);
         bits[i] = o_tx_serial_out[0];
      end
   endtask

   task automatic hold(input int n);
      repeat (n) @(posedge line.tx_line_clock[0]);
      repeat (8) @(posedge i_mclk);
   endtask

   // Reset values and refused addresses
   task automatic t_reset();
      logic [31:0] d;
      `CHK(o_tx_serial_oe, 8'h00)
      rd(ADDR_TX_PATTERN, RESP_OKAY, d);
      `CHK(d, 32'hFF)
      rd(ADDR_CTRL, RESP_OKAY, d);
      `CHK(d, 32'h0)
      wr(8'h18, 32'h1, RESP_SLVERR);
      rd(8'h18, RESP_SLVERR, d);
      `CHK(d, 32'h0)
      $display("reset test done");
   endtask

   // T1 frame: F-bit then slot 0, interrupt masked
   task automatic t_t1();
      logic [31:0] d;
      wr(ADDR_TS_MAP, 32'h1, RESP_OKAY);
      wr(ADDR_TX_PATTERN, 32'h5A, RESP_OKAY);
      sync();
      grab(9);
      `CHK(bits[0:8], 9'h15A)
      `CHK(o_irq, 1'b0)
      rd(ADDR_STATUS, RESP_OKAY, d);
      `CHK(d[23:16], 8'hFF)
      $display("t1 test done");
   endtask

   // Nx64 frame, sync taken on the falling edge: slot 0 leaves four launches later
   task automatic t_nx64();
      wr(ADDR_CTRL, 32'h22, RESP_OKAY);
      wr(ADDR_TX_PATTERN, 32'h3C, RESP_OKAY);
      sync();
      grab(12);
      `CHK(bits[0:11], 12'hF3C)
      $display("nx64 test done");
   endtask

   // E1 frame with or without flywheel, interrupt and idle tristate
   task automatic t_e1(input logic fly);
      logic [31:0] d;
      wr(ADDR_CTRL, {29'h0, fly, 2'h1}, RESP_OKAY);
      wr(ADDR_TX_PATTERN, 32'hA5, RESP_OKAY);
      rd(ADDR_STATUS, RESP_OKAY, d);
      wr(ADDR_MASK, 32'h00FF_0000, RESP_OKAY);
      sync();
      grab(264);
      `CHK(bits[0:7], 8'hA5)
      `CHK(bits[8:15], 8'hFF)
      `CHK(bits[256:263], fly ? 8'hA5 : 8'hFF)
      `CHK(o_irq, 1'b1)
      rd(ADDR_STATUS, RESP_OKAY, d);
      repeat (3) @(posedge i_mclk);
      `CHK(o_irq, 1'b0)
      if (!fly) begin
         `CHK(o_tx_serial_oe, 8'hFF)
         wr(ADDR_CTRL, 32'h9, RESP_OKAY);
         hold(1);
         `CHK(o_tx_serial_oe, 8'h00)
      end
      $display("e1 test done");
   endtask

   // Receive byte of mapped slot 0 on every group
   task automatic t_rx();
      logic [31:0] d;
      wr(ADDR_CTRL, 32'h1, RESP_OKAY);
      rd(ADDR_STATUS, RESP_OKAY, d);
      rx_byte = 8'h96;
      sync();
      hold(10);
      rd(8'h20, RESP_OKAY, d);
      `CHK(d[7:0], 8'h96)
      rd(8'h3C, RESP_OKAY, d);
      `CHK(d[7:0], 8'h96)
      rd(ADDR_STATUS, RESP_OKAY, d);
      `CHK(d[31:24], 8'hFF)
      $display("rx test done");
   endtask

   // Out-of-frame with abort, receive side on falling edges: receive halts, then resumes
   task automatic t_oof();
      logic [31:0] d;
      wr(ADDR_CTRL, 32'hD1, RESP_OKAY);
      rd(ADDR_STATUS, RESP_OKAY, d);
      out_of_frame_condition = 1'b1;
      rx_byte = 8'h69;
      hold(3);
      `CHK(o_out_of_frame_condition, 8'hFF)
      sync();
      hold(10);
      rd(8'h20, RESP_OKAY, d);
      `CHK(d[7:0], 8'h96)
      rd(ADDR_STATUS, RESP_OKAY, d);
      `CHK(d[31:8], 24'h00_FFFF)
      out_of_frame_condition = 1'b0;
      hold(3);
      `CHK(o_out_of_frame_condition, 8'h00)
      sync();
      hold(10);
      rd(8'h20, RESP_OKAY, d);
      `CHK(d[7:0], 8'h69)
      $display("oof test done");
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (16) @(posedge i_mclk);
      i_rst_b <= 1'b1;
      t_reset();
      run = 1'b1;
      t_t1();
      t_nx64();
      t_e1(1'b0);
      t_e1(1'b1);
      t_rx();
      t_oof();
      test_done();
   end
endmodule
